// file: amr_consts.svh
// Register map, field positions, reset values and timing figures
`ifndef AMR_CONSTS_SVH
`define AMR_CONSTS_SVH
`define AMR_ADDR_STANDBY 8'h00
`define AMR_ADDR_SERIAL_MODE 8'h08
`define AMR_ADDR_SIN_ROUTE 8'h09
`define AMR_ADDR_SYNTH_ROUTE 8'h0a
`define AMR_ADDR_SIN_TO_SYNTH 8'h0b
`define AMR_ADDR_INDICATOR 8'h0d
`define AMR_ADDR_GPO 8'h0e
`define AMR_ADDR_SOFT_MUTE 8'h10
`define AMR_ADDR_SYNTH_L_GAIN 8'h11
`define AMR_ADDR_SYNTH_R_GAIN 8'h12
`define AMR_ADDR_SIN_L_GAIN 8'h13
`define AMR_ADDR_SIN_R_GAIN 8'h14
`define AMR_ADDR_STATUS 8'h15
`define AMR_RST_SIN_ROUTE 8'hf0
`define AMR_RST_SYNTH_ROUTE 8'hf0
`define AMR_RST_GAIN 8'hff
`define AMR_RST_ZERO 8'h00
`define AMR_BIT_POLARITY 0
`define AMR_BIT_FORMAT 1
`define AMR_BIT_MASTER 2
`define AMR_BIT_JUSTIFY 3
`define AMR_BIT_SIN_R_TO_SYNTH 0
`define AMR_BIT_SIN_L_TO_SYNTH 2
`define AMR_BIT_SYNTH_MUTE 0
`define AMR_BIT_SIN_MUTE 1
`define AMR_SAMPLE_BITS 16
`define AMR_MUTE_ATTEN 7'h40
`define AMR_CLOCK_PERIOD_NS 8
`define AMR_MUTE_RAMP_TIME_UNIT_MS 8
`define AMR_RAMP_STEPS 63
`define AMR_RAMP_STEP_CYCLES ((`AMR_MUTE_RAMP_TIME_UNIT_MS * 1000000 / `AMR_CLOCK_PERIOD_NS) / `AMR_RAMP_STEPS)
`define AMR_BCLK_HALF_CYCLES 4
`define AMR_BITS_PER_HALF 32
`endif

// file: amr_pkg.sv
// Types shared by the audio mix, route and volume block
package amr_pkg;
  typedef struct packed {
    logic signed [15:0] left;
    logic signed [15:0] right;
  } amr_stereo_type;
  typedef enum logic [1:0] {
    amr_route_through,
    amr_route_cross,
    amr_route_mono,
    amr_route_mute
  } amr_route_type;
  typedef struct packed {
    logic bit_clock;
    logic frame_clock;
  } amr_serial_clocks_type;
endpackage

// file: amr_top.sv
// Audio mix, route, soft mute and digital gain register bank
//
// What this block does
// RL1 - Polarity bit 0: high frame clock carries left; 1: high carries right.
// RL2 - In I2S format the host also sets left-justify and polarity 1.
// RL3 - As slave, the external party supplies bit clock and frame clock.
// RL4 - Serial-in to serial-out selector: through, cross, mono sum, mute.
// RL5 - Serial-in to DAC selector uses same codes; 11b silences its contribution.
// RL6 - Synth to serial-out selector: through, cross, mono (10b), mute; resets mute.
// RL7 - Synth to DAC selector uses same codes and resets to through.
// RL8 - Serial-input routing register resets to f0.
// RL9 - Serial left/right to synth switches pass data when set, silence when clear.
// RL10 - Vibrator and LED bits drive their pins directly, reset low.
// RL11 - Four general output bits drive four pins, reset low.
// RL12 - General output pins keep their values during digital standby.
// RL13 - Mute_ramp_time field sets release time 8, 16, 24 or 32 ms.
// RL14 - Serial-input soft-mute bit applies soft mute to serial input data.
// RL15 - Synth soft-mute bit applies soft mute to synth output.
// RL16 - Gain register: coarse in 7:6, fine in 5:0, gains add.
// RL17 - Four gain registers, each resetting to ff, which mutes.
// RL18 - Coarse gain: 0, +6, +12 dB, or mute for 11b.
// RL19 - Fine gain attenuates 1 dB per step down to -63 dB.
// RL20 - Soft mute ramps gain down and back up over the mute_ramp_time time.
// RL21 - Mono sum saturates at full scale instead of wrapping.
`timescale 1ns/1ns
`include "amr_consts.svh"
module amr_top
  import amr_pkg::*;
#(
  parameter int RAMP_STEP_CYCLES = `AMR_RAMP_STEP_CYCLES,
  parameter int BCLK_HALF_CYCLES = `AMR_BCLK_HALF_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [7:0] o_rdata,
  input wire logic i_bit_clock,
  input wire logic i_frame_clock,
  input wire logic i_serial_audio_in,
  output logic o_serial_audio_out,
  output logic o_bit_clock,
  output logic o_bit_clock_oe,
  output logic o_frame_clock,
  output logic o_frame_clock_oe,
  input wire amr_stereo_type i_synth_sample,
  output amr_stereo_type o_to_synth,
  output amr_stereo_type o_dac_sample,
  output logic o_vibrator_drive,
  output logic o_led_drive,
  output logic [3:0] o_general_out_pins
);
  logic [7:0] standby_ctrl, serial_mode, sin_route, synth_route, sin_to_synth;
  logic [7:0] indicator_outputs, general_output_pins, soft_mute_control;
  logic [7:0] synth_left_gain, synth_right_gain, serial_left_gain, serial_right_gain;

  function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
    if (v > 18'sh07fff) sat16 = 16'sh7fff;
    else if (v < -18'sh08000) sat16 = -16'sh8000;
    else sat16 = v[15:0];
  endfunction

  function automatic logic signed [15:0] route_pick(input logic [1:0] code,
      input logic signed [15:0] same, input logic signed [15:0] opp);
    case (amr_route_type'(code))
      amr_route_through: route_pick = same;
      amr_route_cross: route_pick = opp;
      amr_route_mono: route_pick = sat16(18'(same) + 18'(opp)); // RL21
      default: route_pick = 16'sh0000;
    endcase
  endfunction

  // Gain of 2^(-atten/6) with coarse doubling; ramp attenuation adds to fine
  function automatic logic signed [15:0] apply_gain(input logic signed [15:0] s,
      input logic [7:0] g, input logic [6:0] ramp);
    logic [6:0] atten;
    logic [15:0] mant;
    logic signed [33:0] prod;
    atten = 7'(g[5:0]) + ramp; // RL16 RL19
    case (3'(atten % 7'd6))
      3'd0: mant = 16'h8000;
      3'd1: mant = 16'h7215;
      3'd2: mant = 16'h65ad;
      3'd3: mant = 16'h5a9e;
      3'd4: mant = 16'h50c3;
      default: mant = 16'h47fb;
    endcase
    prod = (34'(s) * $signed({2'b00, mant})) >>> 15;
    prod = (prod >>> (atten / 7'd6)) <<< g[7:6]; // RL18
    if (g[7:6] == 2'b11 || atten >= `AMR_MUTE_ATTEN) apply_gain = 16'sh0000; // RL18
    else if (prod > 34'sh07fff) apply_gain = 16'sh7fff;
    else if (prod < -34'sh08000) apply_gain = -16'sh8000;
    else apply_gain = prod[15:0];
  endfunction

  // Register port
  // Reserved bits are masked on write so they read back as zero
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      standby_ctrl <= `AMR_RST_ZERO;
      serial_mode <= `AMR_RST_ZERO;
      sin_route <= `AMR_RST_SIN_ROUTE; // RL8
      synth_route <= `AMR_RST_SYNTH_ROUTE; // RL6 RL7
      sin_to_synth <= `AMR_RST_ZERO; // RL9
      indicator_outputs <= `AMR_RST_ZERO; // RL10
      general_output_pins <= `AMR_RST_ZERO; // RL11
      soft_mute_control <= `AMR_RST_ZERO;
      synth_left_gain <= `AMR_RST_GAIN; // RL17
      synth_right_gain <= `AMR_RST_GAIN;
      serial_left_gain <= `AMR_RST_GAIN;
      serial_right_gain <= `AMR_RST_GAIN;
    end else if (i_write) begin
      case (i_addr)
        `AMR_ADDR_STANDBY: standby_ctrl <= {7'h00, i_wdata[0]};
        `AMR_ADDR_SERIAL_MODE: serial_mode <= {4'h0, i_wdata[3:0]};
        `AMR_ADDR_SIN_ROUTE: sin_route <= i_wdata;
        `AMR_ADDR_SYNTH_ROUTE: synth_route <= i_wdata;
        `AMR_ADDR_SIN_TO_SYNTH: sin_to_synth <= i_wdata & 8'h05;
        `AMR_ADDR_INDICATOR: indicator_outputs <= i_wdata & 8'h03;
        `AMR_ADDR_GPO: general_output_pins <= i_wdata & 8'h0f;
        `AMR_ADDR_SOFT_MUTE: soft_mute_control <= i_wdata & 8'h0f;
        `AMR_ADDR_SYNTH_L_GAIN: synth_left_gain <= i_wdata;
        `AMR_ADDR_SYNTH_R_GAIN: synth_right_gain <= i_wdata;
        `AMR_ADDR_SIN_L_GAIN: serial_left_gain <= i_wdata;
        `AMR_ADDR_SIN_R_GAIN: serial_right_gain <= i_wdata;
        default: ;
      endcase
    end
  end

  logic [6:0] sin_ramp, synth_ramp;
  wire logic sin_ramp_busy = sin_ramp != 7'h00;
  wire logic synth_ramp_busy = synth_ramp != 7'h00;
  wire logic [7:0] status_value = {6'h00, synth_ramp_busy, sin_ramp_busy};
  logic [7:0] read_value;
  always_comb begin
    case (i_addr)
      `AMR_ADDR_STANDBY: read_value = standby_ctrl;
      `AMR_ADDR_SERIAL_MODE: read_value = serial_mode;
      `AMR_ADDR_SIN_ROUTE: read_value = sin_route;
      `AMR_ADDR_SYNTH_ROUTE: read_value = synth_route;
      `AMR_ADDR_SIN_TO_SYNTH: read_value = sin_to_synth;
      `AMR_ADDR_INDICATOR: read_value = indicator_outputs;
      `AMR_ADDR_GPO: read_value = general_output_pins;
      `AMR_ADDR_SOFT_MUTE: read_value = soft_mute_control;
      `AMR_ADDR_SYNTH_L_GAIN: read_value = synth_left_gain;
      `AMR_ADDR_SYNTH_R_GAIN: read_value = synth_right_gain;
      `AMR_ADDR_SIN_L_GAIN: read_value = serial_left_gain;
      `AMR_ADDR_SIN_R_GAIN: read_value = serial_right_gain;
      `AMR_ADDR_STATUS: read_value = status_value;
      default: read_value = 8'h00;
    endcase
  end
  // Read data are registered and hold until the next read strobe
  always_ff @(posedge i_clock) begin
    if (i_rst) o_rdata <= 8'h00;
    else if (i_read) o_rdata <= read_value;
  end

  // Pins straight from register bits; standby does not touch them
  assign o_vibrator_drive = indicator_outputs[1]; // RL10
  assign o_led_drive = indicator_outputs[0]; // RL10
  assign o_general_out_pins = general_output_pins[3:0]; // RL11 RL12

  wire logic running = standby_ctrl[0];
  wire logic master = serial_mode[`AMR_BIT_MASTER];
  wire logic polarity = serial_mode[`AMR_BIT_POLARITY];
  wire logic i2s_format = serial_mode[`AMR_BIT_FORMAT];
  wire logic justify_select = serial_mode[`AMR_BIT_JUSTIFY];

  // Master clock generator: bit clock from divider, 32 bits per channel
  // Held low while slave, so the pins start quiet when the enables rise
  logic [15:0] div_count;
  logic [4:0] gen_bits;
  amr_serial_clocks_type gen_clocks;
  always_ff @(posedge i_clock) begin
    if (i_rst || !master) begin
      div_count <= 16'h0000;
      gen_bits <= 5'h00;
      gen_clocks <= '0;
    end else if (div_count == 16'(BCLK_HALF_CYCLES - 1)) begin
      div_count <= 16'h0000;
      gen_clocks.bit_clock <= !gen_clocks.bit_clock;
      if (gen_clocks.bit_clock) begin
        gen_bits <= gen_bits + 5'h01;
        if (gen_bits == 5'(`AMR_BITS_PER_HALF - 1))
          gen_clocks.frame_clock <= !gen_clocks.frame_clock;
      end
    end else begin
      div_count <= div_count + 16'h0001;
    end
  end
  assign o_bit_clock = gen_clocks.bit_clock;
  assign o_frame_clock = gen_clocks.frame_clock;
  assign o_bit_clock_oe = master;
  assign o_frame_clock_oe = master;

  // Pin synchronisers; in slave mode the partner drives the clocks (RL3)
  logic [1:0] bclk_sync, ws_sync, sd_sync;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      bclk_sync <= 2'b00;
      ws_sync <= 2'b00;
      sd_sync <= 2'b00;
    end else begin
      bclk_sync <= {bclk_sync[0], i_bit_clock};
      ws_sync <= {ws_sync[0], i_frame_clock};
      sd_sync <= {sd_sync[0], i_serial_audio_in};
    end
  end
  wire logic bclk_now = master ? gen_clocks.bit_clock : bclk_sync[1]; // RL3
  wire logic ws_now = master ? gen_clocks.frame_clock : ws_sync[1];
  logic bclk_prev;
  always_ff @(posedge i_clock) begin
    if (i_rst) bclk_prev <= 1'b0;
    else bclk_prev <= bclk_now;
  end
  wire logic bclk_rise = bclk_now && !bclk_prev;
  wire logic bclk_fall = !bclk_now && bclk_prev;
  // A stalled bit clock freezes both directions; a cut half yields no word left-justified but a partial one right-justified

  // Receiver: bits counted from each frame-clock change
  // Right-justified words are the last 16 bits shifted before the frame edge
  logic [15:0] rx_shift;
  logic [7:0] rx_count, half_len;
  logic rx_ws;
  amr_stereo_type sin_sample;
  wire logic rx_edge = ws_now != rx_ws;
  wire logic [15:0] rx_word = {rx_shift[14:0], sd_sync[1]};
  wire logic [7:0] rx_next = rx_edge ? 8'h01 : rx_count + 8'h01;
  wire logic [7:0] lj_target = 8'(`AMR_SAMPLE_BITS) + {7'h00, i2s_format};
  wire logic rx_is_left = ws_now ^ polarity; // RL1
  wire logic rj_is_left = rx_ws ^ polarity; // RL1
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rx_shift <= 16'h0000;
      rx_count <= 8'h00;
      half_len <= 8'(`AMR_BITS_PER_HALF);
      rx_ws <= 1'b0;
      sin_sample <= '0;
    end else if (bclk_rise) begin
      rx_shift <= rx_word;
      rx_ws <= ws_now;
      rx_count <= (rx_next == 8'hff) ? rx_count : rx_next;
      if (rx_edge) half_len <= rx_count;
      if (!justify_select && rx_edge) begin
        if (rj_is_left) sin_sample.left <= rx_shift;
        else sin_sample.right <= rx_shift;
      end else if (justify_select && rx_next == lj_target) begin
        if (rx_is_left) sin_sample.left <= rx_word;
        else sin_sample.right <= rx_word;
      end
    end
  end

  // Soft mute ramp: one dB per step, step length set by mute_ramp_time field
  // Both paths share one step timer; a new mute_ramp_time applies to the step already in progress
  logic [31:0] ramp_timer;
  wire logic [31:0] step_len = RAMP_STEP_CYCLES * (32'(soft_mute_control[3:2]) + 32'd1); // RL13
  wire logic ramp_tick = ramp_timer >= step_len - 32'd1;
  function automatic logic [6:0] ramp_next(input logic [6:0] r, input logic on);
    if (on && r != `AMR_MUTE_ATTEN) ramp_next = r + 7'h01;
    else if (!on && r != 7'h00) ramp_next = r - 7'h01;
    else ramp_next = r;
  endfunction
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ramp_timer <= 32'd0;
      sin_ramp <= 7'h00;
      synth_ramp <= 7'h00;
    end else begin
      ramp_timer <= ramp_tick ? 32'd0 : ramp_timer + 32'd1;
      if (ramp_tick) begin
        sin_ramp <= ramp_next(sin_ramp, soft_mute_control[`AMR_BIT_SIN_MUTE]); // RL14 RL20
        synth_ramp <= ramp_next(synth_ramp, soft_mute_control[`AMR_BIT_SYNTH_MUTE]); // RL15 RL20
      end
    end
  end

  // Sources after soft mute, then routing and digital gain
  wire amr_stereo_type sin_m = '{left: apply_gain(sin_sample.left, 8'h00, sin_ramp),
    right: apply_gain(sin_sample.right, 8'h00, sin_ramp)}; // RL14
  wire amr_stereo_type syn_m = '{left: apply_gain(i_synth_sample.left, 8'h00, synth_ramp),
    right: apply_gain(i_synth_sample.right, 8'h00, synth_ramp)}; // RL15
  // Serial output takes the routed sum without gain; the DAC path adds gain
  wire logic signed [15:0] sin_sout_l =
    route_pick(sin_route[7:6], sin_m.left, sin_m.right); // RL4
  wire logic signed [15:0] sin_sout_r =
    route_pick(sin_route[5:4], sin_m.right, sin_m.left); // RL4
  wire logic signed [15:0] syn_sout_l =
    route_pick(synth_route[7:6], syn_m.left, syn_m.right); // RL6
  wire logic signed [15:0] syn_sout_r =
    route_pick(synth_route[5:4], syn_m.right, syn_m.left); // RL6
  wire logic signed [15:0] sout_l = sat16(18'(sin_sout_l) + 18'(syn_sout_l));
  wire logic signed [15:0] sout_r = sat16(18'(sin_sout_r) + 18'(syn_sout_r));
  wire logic signed [15:0] sin_dac_l = apply_gain(
    route_pick(sin_route[1:0], sin_m.left, sin_m.right), serial_left_gain, 7'h00); // RL5 RL16
  wire logic signed [15:0] sin_dac_r = apply_gain(
    route_pick(sin_route[3:2], sin_m.right, sin_m.left), serial_right_gain, 7'h00); // RL5 RL16
  wire logic signed [15:0] syn_dac_l = apply_gain(
    route_pick(synth_route[3:2], syn_m.left, syn_m.right), synth_left_gain, 7'h00); // RL7 RL16
  wire logic signed [15:0] syn_dac_r = apply_gain(
    route_pick(synth_route[1:0], syn_m.right, syn_m.left), synth_right_gain, 7'h00); // RL7 RL16
  wire logic signed [15:0] dac_l = sat16(18'(sin_dac_l) + 18'(syn_dac_l));
  wire logic signed [15:0] dac_r = sat16(18'(sin_dac_r) + 18'(syn_dac_r));
  always_ff @(posedge i_clock) begin
    if (i_rst || !running) begin
      o_dac_sample <= '0;
      o_to_synth <= '0;
    end else begin
      o_dac_sample <= '{left: dac_l, right: dac_r};
      o_to_synth.left <= sin_to_synth[`AMR_BIT_SIN_L_TO_SYNTH] ? sin_m.left : 16'sh0000; // RL9
      o_to_synth.right <= sin_to_synth[`AMR_BIT_SIN_R_TO_SYNTH] ? sin_m.right : 16'sh0000; // RL9
    end
  end

  // Transmitter: data changes on falling bit clock, word latched per half
  // Right-justified start uses the half length measured by the receiver
  logic [7:0] tx_pos;
  logic tx_ws;
  logic [15:0] tx_word;
  wire logic [7:0] tx_start = justify_select ? {7'h00, i2s_format} :
    half_len - 8'(`AMR_SAMPLE_BITS);
  wire logic tx_edge = ws_now != tx_ws;
  wire logic [7:0] tx_cur = tx_edge ? 8'h00 : tx_pos + 8'h01;
  wire logic [15:0] tx_cur_word = tx_edge ?
    (((ws_now ^ polarity) ? sout_l : sout_r) & {16{running}}) : tx_word; // RL1
  wire logic [7:0] tx_off = tx_cur - tx_start;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tx_pos <= 8'h00;
      tx_ws <= 1'b0;
      tx_word <= 16'h0000;
      o_serial_audio_out <= 1'b0;
    end else if (bclk_fall) begin
      tx_ws <= ws_now;
      tx_word <= tx_cur_word;
      tx_pos <= (tx_cur == 8'hff) ? tx_pos : tx_cur;
      o_serial_audio_out <= (tx_cur >= tx_start && tx_off < 8'(`AMR_SAMPLE_BITS)) ?
        tx_cur_word[4'(15 - tx_off)] : 1'b0;
    end
  end
endmodule

// file: amr_top_asserts.sv
// Port-level checks for the audio mix register bank
`timescale 1ns/1ns
module amr_top_asserts
  import amr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic [7:0] o_rdata,
  input wire logic o_bit_clock_oe,
  input wire logic o_frame_clock_oe,
  input wire amr_stereo_type o_to_synth,
  input wire logic o_vibrator_drive,
  input wire logic o_led_drive,
  input wire logic [3:0] o_general_out_pins
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  sequence s_feed_cleared;
    i_write && i_addr == 8'h0b && !i_wdata[2] ##1 !(i_write && i_addr == 8'h0b) [*3];
  endsequence
  a_gpo_follows_write: assert property (i_write && i_addr == 8'h0e |=>
    o_general_out_pins == $past(i_wdata[3:0])) else $error("general pins miss write");
  a_indicator_follows_write: assert property (i_write && i_addr == 8'h0d |=>
    {o_vibrator_drive, o_led_drive} == $past(i_wdata[1:0])) else $error("indicator miss");
  a_gpo_holds_value: assert property (!i_rst && !(i_write && i_addr == 8'h0e) |=>
    $stable(o_general_out_pins)) else $error("general pins changed unasked");
  a_unmapped_reads_zero: assert property (i_read && i_addr == 8'h01 |=>
    o_rdata == 8'h00) else $error("unmapped read not zero");
  a_gpo_read_back: assert property (i_read && i_addr == 8'h0e |=>
    o_rdata == {4'h0, o_general_out_pins}) else $error("general pins read back wrong");
  a_rdata_holds: assert property (!i_rst && !i_read |=> $stable(o_rdata))
    else $error("read data moved without read");
  a_oe_master_bit: assert property (i_write && i_addr == 8'h08 |=> ##1
    o_bit_clock_oe == $past(i_wdata[2], 2) && o_frame_clock_oe == $past(i_wdata[2], 2))
    else $error("clock enables disagree with master bit");
  a_feed_silent: assert property (s_feed_cleared |-> o_to_synth.left == 16'h0000)
    else $error("serial feed not silent");
endmodule
bind amr_top amr_top_asserts u_asserts (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
  .o_bit_clock_oe(o_bit_clock_oe), .o_frame_clock_oe(o_frame_clock_oe),
  .o_to_synth(o_to_synth), .o_vibrator_drive(o_vibrator_drive), .o_led_drive(o_led_drive),
  .o_general_out_pins(o_general_out_pins));

// file: amr_serial_partner.sv
// Behavioural serial audio source, left-justified or I2S (i_i2s), 32 bit clocks per channel
`timescale 1ns/1ns
module amr_serial_partner (
  input wire logic i_run,
  input wire logic i_i2s,
  input wire logic [15:0] i_left_word,
  input wire logic [15:0] i_right_word,
  output logic o_bit_clock,
  output logic o_frame_clock,
  output logic o_data
);
  int idx;
  initial begin
    o_bit_clock = 1'b0;
    o_frame_clock = 1'b0;
    o_data = 1'b0;
    forever begin
      wait (i_run);
      for (int ch = 0; ch < 2; ch++) begin
        for (int b = 0; b < 32; b++) begin
          // Word select and data move while the bit clock is low
          // I2S: left on low frame clock, data one bit late
          o_frame_clock = (ch == 0) ^ i_i2s;
          idx = 15 - b + int'(i_i2s);
          if (idx >= 0 && idx < 16) o_data = (ch == 0) ? i_left_word[idx] : i_right_word[idx];
          else o_data = ~o_data;
          #32 o_bit_clock = 1'b1;
          #32 o_bit_clock = 1'b0;
        end
      end
      // Released line shows the inverse of its last bit
      if (!i_run) begin
        o_data = ~o_data;
      end
    end
  end
endmodule

// file: tb_audio_mix_route_volume_ctrl.sv
// Register, pin, routing, gain, soft mute and serial tests for the mix block
`timescale 1ns/1ns
module tb_audio_mix_route_volume_ctrl;
  import amr_pkg::*;
  localparam int STEP = 4;
  logic i_clock, i_rst, i_write, i_read, run;
  logic [7:0] i_addr, i_wdata, o_rdata;
  logic bclk, fclk, sdata, vibrator_drive, led, boe, foe;
  logic [3:0] gpo;
  logic sout, mbclk, mfclk, mb0, mf0, i2s, sout_ws = 1'b0;
  logic [15:0] sout_cap, sout_left;
  int sout_n = 0;
  amr_stereo_type synth, to_synth, dac;
  int mismatches, checked;
  int cycles = 0;
  logic [15:0] rtab [11] = '{16'h09f0, 16'h0af0, 16'h0b00, 16'h0d00, 16'h0e00, 16'h1000,
    16'h11ff, 16'h12ff, 16'h13ff, 16'h14ff, 16'h0100};
  logic [15:0] lexp [4] = '{16'h1234, 16'h0567, 16'h179b, 16'h0000};
  logic [15:0] rexp [4] = '{16'h0567, 16'h1234, 16'h179b, 16'h0000};
  logic [15:0] gexp [4] = '{16'h1234, 16'h2468, 16'h48d0, 16'h0000};
  amr_top #(.RAMP_STEP_CYCLES(STEP)) u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
    .i_bit_clock(bclk), .i_frame_clock(fclk), .i_serial_audio_in(sdata),
    .o_serial_audio_out(sout), .o_bit_clock(mbclk), .o_bit_clock_oe(boe),
    .o_frame_clock(mfclk),
    .o_frame_clock_oe(foe), .i_synth_sample(synth), .o_to_synth(to_synth), .o_dac_sample(dac),
    .o_vibrator_drive(vibrator_drive), .o_led_drive(led), .o_general_out_pins(gpo));
  amr_serial_partner u_partner (.i_run(run), .i_i2s(i2s), .i_left_word(16'ha5c3),
    .i_right_word(16'h3c5a), .o_bit_clock(bclk), .o_frame_clock(fclk), .o_data(sdata));
  // Bench receiver: first 16 bits of each frame-high half of the serial output
  always @(posedge bclk) begin
    sout_n = (fclk != sout_ws) ? 0 : sout_n + 1;
    sout_ws = fclk;
    if (sout_n < 16) sout_cap = {sout_cap[14:0], sout};
    if (sout_n == 15 && fclk) sout_left = sout_cap;
  end
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_write <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
    #1;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 cmp({8'h00, o_rdata}, {8'h00, e});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic put(input logic [15:0] l, input logic [15:0] r);
    @(posedge i_clock);
    synth <= {l, r};
  endtask
  initial begin
    i_rst = 1'b1;
    i_write = 1'b0;
    i_read = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    run = 1'b0;
    i2s = 1'b0;
    synth = '0;
    mismatches = 0;
    checked = 0;
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    foreach (rtab[k]) rc(rtab[k][15:8], rtab[k][7:0]);
    cmp({10'h000, vibrator_drive, led, gpo}, 16'h0000);
    $display("reset values done");
    wr(8'h0d, 8'hff);
    rc(8'h0d, 8'h03);
    wr(8'h0e, 8'hff);
    rc(8'h0e, 8'h0f);
    wr(8'h0d, 8'h02);
    wr(8'h0e, 8'h05);
    wr(8'h00, 8'h00);
    cmp({10'h000, vibrator_drive, led, gpo}, 16'h0025);
    wr(8'h01, 8'hff);
    rc(8'h01, 8'h00);
    $display("pins done");
    wr(8'h00, 8'h01);
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h00);
    put(16'h1234, 16'h0567);
    for (int c = 0; c < 4; c++) begin
      wr(8'h0a, {4'hf, c[1:0], c[1:0]});
      idle(8);
      cmp(dac.left, lexp[c]);
      cmp(dac.right, rexp[c]);
    end
    put(16'h7000, 16'h6000);
    wr(8'h0a, 8'hfa);
    idle(8);
    cmp(dac.left, 16'h7fff);
    put(16'h1234, 16'h0567);
    wr(8'h0a, 8'hf0);
    for (int g = 0; g < 4; g++) begin
      wr(8'h11, {g[1:0], 6'h00});
      idle(8);
      cmp(dac.left, gexp[g]);
    end
    wr(8'h11, 8'hff);
    idle(8);
    cmp(dac.left, 16'h0000);
    $display("routes and gains done");
    wr(8'h11, 8'h00);
    wr(8'h10, 8'h01);
    idle(64 * STEP + 40);
    cmp(dac.left, 16'h0000);
    rc(8'h15, 8'h02);
    wr(8'h10, 8'h0c);
    idle(600);
    rc(8'h15, 8'h02);
    idle(600);
    cmp(dac.left, 16'h1234);
    rc(8'h15, 8'h00);
    $display("soft mute done");
    wr(8'h08, 8'h08);
    wr(8'h0b, 8'h05);
    wr(8'h09, 8'h00);
    @(posedge i_clock);
    run <= 1'b1;
    idle(1600);
    cmp(sout_left, 16'ha5c3);
    cmp(to_synth.left, 16'ha5c3);
    cmp(to_synth.right, 16'h3c5a);
    wr(8'h08, 8'h09);
    idle(1600);
    cmp(to_synth.left, 16'h3c5a);
    cmp(to_synth.right, 16'ha5c3);
    wr(8'h08, 8'h0b);
    @(posedge i_clock);
    i2s <= 1'b1;
    idle(1600);
    cmp(to_synth.left, 16'ha5c3);
    cmp(to_synth.right, 16'h3c5a);
    wr(8'h08, 8'h00);
    @(posedge i_clock);
    i2s <= 1'b0;
    idle(1600);
    cmp(to_synth.left, 16'h5555);
    cmp(to_synth.right, 16'haaaa);
    wr(8'h0b, 8'h00);
    idle(8);
    cmp(to_synth.left | to_synth.right, 16'h0000);
    wr(8'h08, 8'h0c);
    idle(2);
    cmp({14'h0000, boe, foe}, 16'h0003);
    mb0 = mbclk;
    mf0 = mfclk;
    idle(4);
    cmp({15'h0000, mbclk}, {15'h0000, ~mb0});
    idle(252);
    cmp({15'h0000, mfclk}, {15'h0000, ~mf0});
    wr(8'h08, 8'h08);
    @(posedge i_clock);
    run <= 1'b0;
    $display("serial done");
    results();
  end
endmodule
